// ===== design/phy_event_irq_and_loopback_regs.sv
// Notes on behaviour
// - reg 0x12 bit 15 link-quality-bad flag, read only; bit 7 its enable.
// - reg 0x12 bit 14 energy-detect change flag; bit 6 its enable.
// - reg 0x12 bit 13 link status change flag; bit 5 its enable.
// - reg 0x12 bit 11 ESD fault flag; bit 3 its enable.
// - reg 0x12 bit 10 training complete flag; bit 2 its enable.
// - reg 0x13 bit 15 under-voltage flag; bit 7 its enable.
// - reg 0x13 bit 14 over-voltage flag; bit 6 its enable.
// - reg 0x13 bit 11 over-temperature flag; bit 3 its enable.
// - reg 0x13 bit 10 sleep mode change flag; bit 2 its enable.
// - reg 0x13 bit 9 polarity change flag; bit 1 its enable.
// - reg 0x13 bit 8 one-hot check failure flag; bit 0 its enable.
// - reg 0x16 bit 10 sticky PRBS lock loss; software writes 0 to clear.
// - reg 0x16 bit 8 reads 1 in normal power, 0 when down or asleep.
// - reg 0x16 bits 6-0 one-hot loopback selector, read/write.
// - global interrupt enable gates every event from the pin.
// - polarity bit: 1 makes interrupt pin active low, 0 active high.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module phy_event_irq_and_loopback_regs (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        nrst,
	// register port
	input  wire logic [4:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// event pulses, link group: 7 qual, 6 energy, 5 link, 3 esd, 2 training
	input  wire logic [7:0]  link_events,
	// event pulses, power group: 7 uv, 6 ov, 3 temp, 2 sleep, 1 pol, 0 one-hot
	input  wire logic [7:0]  power_events,
	// status inputs
	input  wire logic        prbs_lock_lost,
	input  wire logic        core_normal_power,
	// loopback controls out
	output logic             dig_pcs_loopback,
	output logic      [6:0]  loopback_select,
	// interrupt pin
	output logic             irq_pin
);
	// ********************
	// input synchronisers
	// ********************
	logic [17:0] sync_a;
	logic [17:0] sync_b;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sync_a <= 18'h00000;
			sync_b <= 18'h00000;
		end else begin
			sync_a <= {core_normal_power, prbs_lock_lost, power_events, link_events};
			sync_b <= sync_a;
		end
	end
	wire logic [7:0] link_ev_s  = sync_b[7:0];
	wire logic [7:0] power_ev_s = sync_b[15:8];
	wire logic       prbs_s     = sync_b[16];
	wire logic       core_pwr_s = sync_b[17];

	// ********************
	// address decode
	// ********************
	wire logic sel_link  = (reg_addr == phy_irq_pkg::LINK_EVT_OFFSET);
	wire logic sel_power = (reg_addr == phy_irq_pkg::POWER_EVT_OFFSET);
	wire logic sel_loop  = (reg_addr == phy_irq_pkg::LOOP_CTRL_OFFSET);
	wire logic sel_ctrl  = (reg_addr == phy_irq_pkg::IRQ_CTRL_OFFSET);

	// ********************
	// register state
	// ********************
	logic [7:0] link_flags;
	logic [7:0] link_en;
	logic [7:0] power_flags;
	logic [7:0] power_en;
	logic       prbs_loss;
	logic       dig_loop;
	logic [6:0] loop_sel;
	logic       irq_en;
	logic       irq_pol;

	// read clears flags; a new event in the same cycle wins
	wire logic [7:0] next_link_flags  = (link_flags & ~{8{reg_rd & sel_link}})
		| (link_ev_s & phy_irq_pkg::LINK_EVT_MASK);
	wire logic [7:0] next_power_flags = (power_flags & ~{8{reg_rd & sel_power}})
		| (power_ev_s & phy_irq_pkg::POWER_EVT_MASK);
	// write of 0 clears, lock loss in same cycle wins
	wire logic       next_prbs_loss   = prbs_s
		| (prbs_loss & ~(reg_wr & sel_loop & ~reg_wdata[phy_irq_pkg::PRBS_LOSS_BIT]));

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			link_flags  <= phy_irq_pkg::LINK_EVT_RESET[15:8];
			power_flags <= phy_irq_pkg::POWER_EVT_RESET[15:8];
			prbs_loss   <= phy_irq_pkg::LOOP_CTRL_RESET[10];
		end else begin
			link_flags  <= next_link_flags;
			power_flags <= next_power_flags;
			prbs_loss   <= next_prbs_loss;
		end
	end

	// enables, including reserved ones that only store
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			link_en  <= phy_irq_pkg::LINK_EVT_RESET[7:0];
			power_en <= phy_irq_pkg::POWER_EVT_RESET[7:0];
		end else begin
			if (reg_wr && sel_link) begin
				link_en <= reg_wdata[7:0];
			end
			if (reg_wr && sel_power) begin
				power_en <= reg_wdata[7:0];
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			dig_loop <= phy_irq_pkg::LOOP_CTRL_RESET[7];
			loop_sel <= phy_irq_pkg::LOOP_CTRL_RESET[6:0];
		end else if (reg_wr && sel_loop) begin
			dig_loop <= reg_wdata[phy_irq_pkg::DIG_LOOP_BIT];
			loop_sel <= reg_wdata[6:0];
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			irq_en  <= phy_irq_pkg::IRQ_EN_RESET;
			irq_pol <= phy_irq_pkg::IRQ_POL_RESET;
		end else if (reg_wr && sel_ctrl) begin
			irq_en  <= reg_wdata[phy_irq_pkg::IRQ_EN_BIT];
			irq_pol <= reg_wdata[phy_irq_pkg::IRQ_POL_BIT];
		end
	end

	// ********************
	// interrupt
	// ********************
	wire logic link_hit  = |(link_flags & link_en & phy_irq_pkg::LINK_EVT_MASK);
	wire logic power_hit = |(power_flags & power_en & phy_irq_pkg::POWER_EVT_MASK);
	wire logic irq_active = irq_en & (link_hit | power_hit);
	logic irq_q;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			irq_q <= phy_irq_pkg::IRQ_POL_RESET;
		end else begin
			irq_q <= irq_active ^ irq_pol;
		end
	end
	assign irq_pin = irq_q;

	// ********************
	// read path
	// ********************
	wire logic [15:0] link_word  = {link_flags, link_en};
	wire logic [15:0] power_word = {power_flags, power_en};
	wire logic [15:0] loop_word  = {5'h00, prbs_loss, 1'b0, core_pwr_s, dig_loop, loop_sel};
	wire logic [15:0] ctrl_word  = {12'h000, irq_pol, 1'b0, irq_en, 1'b0};
	wire logic [15:0] rd_mux =
		sel_link  ? link_word  :
		sel_power ? power_word :
		sel_loop  ? loop_word  :
		sel_ctrl  ? ctrl_word  : 16'h0000;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			reg_rdata <= rd_mux;
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	assign dig_pcs_loopback = dig_loop;
	assign loopback_select  = loop_sel;
endmodule
`default_nettype wire

// ===== pkg/phy_irq_pkg.sv
`default_nettype none
package phy_irq_pkg;
	// ********************
	// register offsets
	// ********************
	localparam logic [4:0]  LINK_EVT_OFFSET  = 5'h12;
	localparam logic [4:0]  POWER_EVT_OFFSET = 5'h13;
	localparam logic [4:0]  LOOP_CTRL_OFFSET = 5'h16;
	localparam logic [4:0]  IRQ_CTRL_OFFSET  = 5'h11;
	localparam int          ADDR_W           = 5;
	localparam int          DATA_W           = 16;
	// ********************
	// reset values
	// ********************
	localparam logic [15:0] LINK_EVT_RESET   = 16'h0000;
	localparam logic [15:0] POWER_EVT_RESET  = 16'h0000;
	localparam logic [15:0] LOOP_CTRL_RESET  = 16'h0000;
	localparam logic        IRQ_EN_RESET     = 1'b1;
	localparam logic        IRQ_POL_RESET    = 1'b1;
	// ********************
	// field positions
	// ********************
	localparam int          STATUS_LSB       = 8;
	localparam logic [7:0]  LINK_EVT_MASK    = 8'hec;
	localparam logic [7:0]  POWER_EVT_MASK   = 8'hcf;
	localparam int          IRQ_EN_BIT       = 1;
	localparam int          IRQ_POL_BIT      = 3;
	localparam int          PRBS_LOSS_BIT    = 10;
	localparam int          CORE_PWR_BIT     = 8;
	localparam int          DIG_LOOP_BIT     = 7;
	localparam int          LOOP_SEL_W       = 7;
	// ********************
	// loopback codes
	// ********************
	localparam logic [6:0]  LOOP_NONE        = 7'h00;
	localparam logic [6:0]  LOOP_PCS         = 7'h01;
	localparam logic [6:0]  LOOP_RS          = 7'h02;
	localparam logic [6:0]  LOOP_DIGITAL     = 7'h04;
	localparam logic [6:0]  LOOP_ANALOG      = 7'h08;
	localparam logic [6:0]  LOOP_REVERSE     = 7'h10;
endpackage
`default_nettype wire

// ===== tb/phy_irq_sva.sv
`timescale 1ns/1ps
`default_nettype none
module phy_irq_sva (
	input wire logic        core_clk,
	input wire logic        nrst,
	input wire logic [4:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic [7:0]  link_events,
	input wire logic [7:0]  power_events,
	input wire logic        prbs_lock_lost,
	input wire logic        core_normal_power,
	input wire logic        dig_pcs_loopback,
	input wire logic [6:0]  loopback_select,
	input wire logic        irq_pin
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	wire rd16 = reg_rd && reg_addr == 5'h16;
	wire wr16 = reg_wr && reg_addr == 5'h16;
	wire acc  = reg_wr || reg_rd;
	wire ev   = |{link_events, power_events};
	chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("rdata not idle");
	chk_unmapped_read: assert property (reg_rd && !(reg_addr inside {5'h11, 5'h12, 5'h13, 5'h16}) |=> reg_rdata == 16'h0000)
		else $error("unmapped read");
	chk_irq_cause: assert property ($changed(irq_pin) |-> $past(acc) || $past(acc, 2) || $past(ev, 3) || $past(ev, 4))
		else $error("irq change");
	chk_power_on: assert property (core_normal_power [*4] ##0 rd16 |=> reg_rdata[8])
		else $error("power bit");
	chk_status_rsvd: assert property (reg_rd && reg_addr == 5'h12 |=> reg_rdata[12] == 1'b0 && reg_rdata[9:8] == 2'h0)
		else $error("reserved status");
	chk_loop_hold: assert property (!wr16 |=> $stable(loopback_select) && $stable(dig_pcs_loopback))
		else $error("loop changed");
	chk_loop_read: assert property (rd16 |=> reg_rdata[7:0] == {dig_pcs_loopback, loopback_select})
		else $error("loop read");
	chk_loop_write: assert property (wr16 |=> {dig_pcs_loopback, loopback_select} == $past(reg_wdata[7:0]))
		else $error("loop write");
endmodule
bind phy_event_irq_and_loopback_regs phy_irq_sva u_sva (.*);
`default_nettype wire

// ===== tb/test_phy_event_irq_and_loopback_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_phy_event_irq_and_loopback_regs;
	logic        core_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic        prbs_lock_lost = 1'b0, core_normal_power = 1'b1;
	logic [4:0]  reg_addr = 5'h00;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata;
	logic [7:0]  link_events = 8'h00, power_events = 8'h00;
	logic        dig_pcs_loopback, irq_pin;
	logic [6:0]  loopback_select;
	int          n_fail = 0, cmp_count = 0, cyc = 0;
	phy_event_irq_and_loopback_regs dut (.*);
	initial forever #50 core_clk = ~core_clk;
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge core_clk);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		@(posedge core_clk);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk("rdata", reg_rdata, e);
	endtask
	task automatic pulse(input logic [16:0] v);
		@(posedge core_clk);
		{prbs_lock_lost, power_events, link_events} <= v;
		@(posedge core_clk);
		{prbs_lock_lost, power_events, link_events} <= 17'h00000;
		repeat (5) @(posedge core_clk);
		#1;
	endtask
	task automatic irq(input logic e);
		chk("irq_pin", {15'h0000, irq_pin}, {15'h0000, e});
	endtask
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	initial begin
		logic [15:0] v;
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		rd(5'h11, 16'h000a);
		rd(5'h16, 16'h0100);
		rd(5'h14, 16'h0000);
		wr(5'h14, 16'hffff);
		rd(5'h14, 16'h0000);
		wr(5'h12, 16'hffff);
		rd(5'h12, 16'h00ff);
		wr(5'h13, 16'hffff);
		rd(5'h13, 16'h00ff);
		for (int i = 0; i < 16; i++) if (16'hcfec & (16'h0001 << i)) begin
			wr(5'h12 + 5'(i / 8), 16'h0001 << (i % 8));
			pulse(17'h00001 << i);
			irq(1'b0);
			rd(5'h12 + 5'(i / 8), 16'h0101 << (i % 8));
			rd(5'h12 + 5'(i / 8), 16'h0001 << (i % 8));
			irq(1'b1);
		end
		wr(5'h12, 16'h0013);
		wr(5'h13, 16'h0030);
		pulse(17'h03033);
		irq(1'b1);
		rd(5'h12, 16'h2013);
		rd(5'h13, 16'h0030);
		wr(5'h11, 16'h0008);
		wr(5'h12, 16'h0020);
		pulse(17'h00020);
		irq(1'b1);
		wr(5'h11, 16'h000a);
		repeat (2) @(posedge core_clk);
		#1 irq(1'b0);
		wr(5'h11, 16'h0002);
		repeat (2) @(posedge core_clk);
		#1 irq(1'b1);
		rd(5'h12, 16'h2020);
		repeat (2) @(posedge core_clk);
		#1 irq(1'b0);
		for (int i = 0; i < 5; i++) begin
			v = (16'h0001 << i) | (16'(i % 2) << 7);
			wr(5'h16, v);
			chk("loopback", {8'h00, dig_pcs_loopback, loopback_select}, v);
			rd(5'h16, v | 16'h0100);
		end
		@(posedge core_clk);
		core_normal_power <= 1'b0;
		repeat (4) @(posedge core_clk);
		rd(5'h16, 16'h0010);
		wr(5'h16, 16'h0400);
		rd(5'h16, 16'h0000);
		pulse(17'h10000);
		rd(5'h16, 16'h0400);
		wr(5'h16, 16'h0000);
		rd(5'h16, 16'h0000);
		tally_and_finish();
	end
endmodule
`default_nettype wire
